// >>> core/bus_wait_pkg.sv
package bus_wait_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [3:0]  CS_WAIT_OFFSET    = 4'h0;
  localparam logic [3:0]  DMA_WAIT_OFFSET   = 4'h4;
  localparam logic [3:0]  WAIT_STAT_OFFSET  = 4'h8;

  // power-on reset values
  localparam logic [15:0] CS_WAIT_RESET     = 16'hFFFF;
  localparam logic [5:0]  DMA_WAIT_RESET    = 6'h0F;

  // field layout
  localparam int          CS_FIELD_W        = 4;
  localparam int          CS_SPACES         = 4;
  localparam int          DMA_WIDTH         = 6;
  localparam int          DRAM_DMA_LSB      = 4;
  localparam int          CS_DMA_LSB        = 0;
  localparam int          DRAM_BASE_CYCLES  = 2;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // access target spaces
  typedef enum logic [2:0] {
    SPACE_CS0  = 3'b000,
    SPACE_CS1  = 3'b001,
    SPACE_CS2  = 3'b010,
    SPACE_CS3  = 3'b011,
    SPACE_DRAM = 3'b100
  } space_t;

  // wait sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b10,
    ST_DONE = 2'b11
  } wait_state_t;

  // access request from the bus cycle generator
  typedef struct packed {
    logic      start;
    space_t    space;
    logic      dma_single;
    logic      write;
  } access_req_t;

  // access status back to the bus cycle generator
  typedef struct packed {
    logic       busy;
    logic       ext_wait_en;
    logic       in_wait;
    logic       done;
  } access_stat_t;

  // whole state of the block
  typedef struct packed {
    logic [15:0] cs_wait;
    logic [5:0]  dma_wait;
    logic [3:0]  aw_addr;
    logic        aw_have;
    logic [15:0] w_data;
    logic [1:0]  w_strb;
    logic        w_have;
    logic        b_valid;
    logic [1:0]  b_resp;
    logic        r_valid;
    logic [31:0] r_data;
    logic [1:0]  r_resp;
    wait_state_t st;
    logic [3:0]  count;
    logic        ext_en;
    logic        pin_meta;
    logic        pin_sync;
  } wait_ctl_state_t;

  localparam wait_ctl_state_t STATE_RESET = '{
    cs_wait:  CS_WAIT_RESET,
    dma_wait: DMA_WAIT_RESET,
    aw_addr:  4'h0,
    aw_have:  1'b0,
    w_data:   16'h0000,
    w_strb:   2'h0,
    w_have:   1'b0,
    b_valid:  1'b0,
    b_resp:   RESP_OKAY,
    r_valid:  1'b0,
    r_data:   32'h00000000,
    r_resp:   RESP_OKAY,
    st:       ST_IDLE,
    count:    4'h0,
    ext_en:   1'b0,
    pin_meta: 1'b0,
    pin_sync: 1'b0
  };

endpackage : bus_wait_pkg

// >>> core/external_bus_wait_control.sv
`timescale 1ns/100ps
`default_nettype none
module external_bus_wait_control
  import bus_wait_pkg::*;
(
  // clock and power-on reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_i,
  // manual reset and software standby, same clock domain
  input  wire logic         manual_reset_i,
  input  wire logic         software_standby_i,
  // AXI4-Lite write address
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  input  wire logic [3:0]   s_axi_awaddr_i,
  // AXI4-Lite write data
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  // AXI4-Lite write response
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  output logic [1:0]        s_axi_bresp_o,
  // AXI4-Lite read address
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  input  wire logic [3:0]   s_axi_araddr_i,
  // AXI4-Lite read data
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  // normal DRAM wait codes from the DRAM area control
  input  wire logic [1:0]   dram_read_wait_field_i,
  input  wire logic [1:0]   dram_write_wait_field_i,
  // access request and status
  input  wire access_req_t  access_req_i,
  output access_stat_t      access_stat_o,
  // external wait pin, asynchronous, active low
  input  wire logic         ext_wait_n_i
);

  wait_ctl_state_t s_q;             // registered state
  wait_ctl_state_t s_d;             // next state
  logic            wr_commit;       // write address and data both held
  logic            wr_hit_cs;       // write decodes the per-space register
  logic            wr_hit_dma;      // write decodes the DMA register
  logic [3:0]      sel_waits;       // wait count chosen for a new access
  logic            sel_ext;         // wait pin enabled for a new access
  logic            pin_active;      // synchronised wait request
  logic            start_ok;        // access accepted this cycle
  logic [15:0]     wmask;           // byte lane mask of the write

  // per-space wait counts as separate fields
  logic [3:0]      cs_count [CS_SPACES];

  genvar gi;
  generate
    for (gi = 0; gi < CS_SPACES; gi++)
    begin : g_cs_field
      // each space owns its own nibble
      assign cs_count[gi] = s_q.cs_wait[gi*CS_FIELD_W +: CS_FIELD_W];
    end
  endgenerate

  // write decode
  assign wr_commit  = s_q.aw_have && s_q.w_have && !s_q.b_valid;
  assign wr_hit_cs  = (s_q.aw_addr == CS_WAIT_OFFSET);
  assign wr_hit_dma = (s_q.aw_addr == DMA_WAIT_OFFSET);
  assign wmask      = {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
  assign pin_active = s_q.pin_sync;
  assign start_ok   = access_req_i.start && (s_q.st == ST_IDLE)
                      && !manual_reset_i && !software_standby_i;

  // wait selection for the requested space and mode
  always_comb
  begin
    sel_waits = 4'h0;
    sel_ext   = 1'b0;
    if (access_req_i.space == SPACE_DRAM)
    begin
      // dram: code 00..11 gives 0..3 waits, pin enabled for upper half
      if (access_req_i.dma_single)
      begin
        sel_waits = {2'b00, s_q.dma_wait[DRAM_DMA_LSB +: 2]};
        sel_ext   = s_q.dma_wait[DRAM_DMA_LSB + 1];
      end
      else if (access_req_i.write)
      begin
        sel_waits = {2'b00, dram_write_wait_field_i};
        sel_ext   = dram_write_wait_field_i[1];
      end
      else
      begin
        sel_waits = {2'b00, dram_read_wait_field_i};
        sel_ext   = dram_read_wait_field_i[1];
      end
    end
    else if (access_req_i.dma_single)
    begin
      // chip-select in DMA single address mode uses its own count
      sel_waits = s_q.dma_wait[CS_DMA_LSB +: CS_FIELD_W];
      sel_ext   = (sel_waits != 4'h0);
    end
    else
    begin
      // ordinary chip-select access uses its space's nibble
      sel_waits = cs_count[access_req_i.space[1:0]];
      sel_ext   = (sel_waits != 4'h0);
    end
  end

  // next-state logic for the bus slave and the wait sequencer
  always_comb
  begin
    s_d = s_q;

    // wait pin synchroniser, active low at the pin
    s_d.pin_meta = !ext_wait_n_i;
    s_d.pin_sync = s_q.pin_meta;

    // write address channel
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      s_d.aw_addr = s_axi_awaddr_i;
      s_d.aw_have = 1'b1;
    end
    // write data channel
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      s_d.w_data = s_axi_wdata_i[15:0];
      s_d.w_strb = s_axi_wstrb_i[1:0];
      s_d.w_have = 1'b1;
    end

    // both halves present: update register and answer
    if (wr_commit)
    begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.b_valid = 1'b1;
      s_d.b_resp  = RESP_OKAY;
      if (wr_hit_cs)
      begin
        s_d.cs_wait = (s_q.cs_wait & ~wmask) | (s_q.w_data & wmask);
      end
      else if (wr_hit_dma)
      begin
        // only the low six bits exist; upper bits are dropped
        if (s_q.w_strb[0])
        begin
          s_d.dma_wait = s_q.w_data[DMA_WIDTH-1:0];
        end
      end
      else if (s_q.aw_addr != WAIT_STAT_OFFSET)
      begin
        s_d.b_resp = RESP_SLVERR;
      end
    end
    // write response retires
    if (s_q.b_valid && s_axi_bready_i)
    begin
      s_d.b_valid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_d.r_valid = 1'b1;
      s_d.r_resp  = RESP_OKAY;
      unique case (s_axi_araddr_i)
        CS_WAIT_OFFSET:   s_d.r_data = {16'h0000, s_q.cs_wait};
        DMA_WAIT_OFFSET:  s_d.r_data = {26'h0000000, s_q.dma_wait};
        WAIT_STAT_OFFSET: s_d.r_data = {24'h000000, s_q.count,
                                        s_q.ext_en, s_q.pin_sync, s_q.st};
        default:
        begin
          s_d.r_data = 32'h00000000;
          s_d.r_resp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_q.r_valid && s_axi_rready_i)
    begin
      s_d.r_valid = 1'b0;
    end

    // wait sequencer
    unique case (s_q.st)
      ST_IDLE:
      begin
        if (start_ok)
        begin
          s_d.count  = sel_waits;
          s_d.ext_en = sel_ext;
          // zero waits: finish at once and never look at the pin
          s_d.st     = (sel_waits == 4'h0) ? ST_DONE : ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        // one cycle per programmed wait
        if (s_q.count == 4'h1)
        begin
          s_d.count = 4'h0;
          s_d.st    = (s_q.ext_en && pin_active) ? ST_HOLD : ST_DONE;
        end
        else
        begin
          s_d.count = s_q.count - 4'h1;
        end
      end
      ST_HOLD:
      begin
        // stretch while the external device holds the pin
        if (!pin_active)
        begin
          s_d.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        s_d.st     = ST_IDLE;
        s_d.ext_en = 1'b0;
      end
    endcase

    // manual reset aborts the access but keeps both registers
    if (manual_reset_i)
    begin
      s_d.st     = ST_IDLE;
      s_d.count  = 4'h0;
      s_d.ext_en = 1'b0;
    end
  end

  // state register; only power-on reset restores the wait settings
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      s_q <= STATE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // bus handshakes
  assign s_axi_awready_o = !s_q.aw_have && !s_q.b_valid;
  assign s_axi_wready_o  = !s_q.w_have && !s_q.b_valid;
  assign s_axi_arready_o = !s_q.r_valid;
  assign s_axi_bvalid_o  = s_q.b_valid;
  assign s_axi_bresp_o   = s_q.b_resp;
  assign s_axi_rvalid_o  = s_q.r_valid;
  assign s_axi_rdata_o   = s_q.r_data;
  assign s_axi_rresp_o   = s_q.r_resp;

  // access status, decoded from registered state
  assign access_stat_o.busy        = (s_q.st != ST_IDLE);
  assign access_stat_o.ext_wait_en = s_q.ext_en;
  assign access_stat_o.in_wait     = (s_q.st == ST_WAIT) || (s_q.st == ST_HOLD);
  assign access_stat_o.done        = (s_q.st == ST_DONE);

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  chk_reset_values: assert property (
    $past(reset_i) |-> (s_q.cs_wait == CS_WAIT_RESET) && (s_q.dma_wait == DMA_WAIT_RESET))
    else $error("wait registers not at power-on values");

  chk_manual_keeps: assert property (
    (manual_reset_i && !wr_commit) |=> $stable(s_q.cs_wait) && $stable(s_q.dma_wait))
    else $error("manual reset changed wait registers");

  chk_zero_no_wait: assert property (
    (start_ok && sel_waits == 4'h0) |=> (s_q.st == ST_DONE) ##1 (s_q.st == ST_IDLE))
    else $error("zero count access did not finish at once");

  chk_wait_load: assert property (
    (start_ok && sel_waits != 4'h0) |=> (s_q.st == ST_WAIT) && (s_q.count == $past(sel_waits)))
    else $error("wait count not loaded");

  chk_wait_step: assert property (
    (s_q.st == ST_WAIT && s_q.count > 4'h1 && !manual_reset_i)
      |=> (s_q.st == ST_WAIT) && (s_q.count == $past(s_q.count) - 4'h1))
    else $error("wait count did not step by one");

  chk_hold_extend: assert property (
    (s_q.st == ST_HOLD && pin_active && !manual_reset_i) |=> (s_q.st == ST_HOLD))
    else $error("access ended while wait pin held");

  chk_hold_needs_en: assert property (
    (s_q.st == ST_HOLD) |-> s_q.ext_en)
    else $error("wait pin honoured while disabled");

  chk_dram_dma_sel: assert property (
    (start_ok && access_req_i.space == SPACE_DRAM && access_req_i.dma_single)
      |=> (s_q.ext_en == s_q.dma_wait[DRAM_DMA_LSB + 1]))
    else $error("dram dma wait enable wrong");

  chk_cs_dma_sel: assert property (
    (start_ok && access_req_i.space != SPACE_DRAM && access_req_i.dma_single
      && s_q.dma_wait[3:0] != 4'h0) |=> (s_q.count == $past(s_q.dma_wait[3:0])))
    else $error("chip-select dma count wrong");

  chk_reserved_zero: assert property (
    (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == DMA_WAIT_OFFSET)
      |=> (s_axi_rdata_o[31:6] == 26'h0000000))
    else $error("reserved bits read non-zero");

  // main scenarios
  cov_hold_seen:  cover property ((s_q.st == ST_WAIT) ##1 (s_q.st == ST_HOLD) [*3]);
  cov_cs_write:   cover property (wr_commit && wr_hit_cs);
  cov_dram_dma:   cover property (start_ok && access_req_i.space == SPACE_DRAM
                                  && access_req_i.dma_single);
  cov_zero_wait:  cover property (start_ok && sel_waits == 4'h0);

endmodule : external_bus_wait_control
`default_nettype wire

// >>> verif/ext_wait_device.sv
`timescale 1ns/100ps
`default_nettype none
module ext_wait_device
(
  // clock and command from the bench
  input  wire logic       clk_sys_i,
  input  wire logic       go_i,
  input  wire logic [7:0] hold_i,
  // wait pin, pulled up while released
  output logic            wait_n_o
);
  logic [7:0] left_q = 8'h00; // cycles still held low
  // reload on a new access, then count down to release
  always_ff @(posedge clk_sys_i)
  begin
    if (go_i)
      left_q <= hold_i;
    else if (left_q != 8'h00)
      left_q <= left_q - 8'h01;
  end
  // pin low while holding, pull-up level once released
  assign wait_n_o = (left_q == 8'h00);
endmodule : ext_wait_device
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import bus_wait_pkg::*;
  // clock, resets and modes
  logic         clk_sys_i = 1'b0;
  logic         reset_i   = 1'b1;
  logic         man_rst   = 1'b0;
  logic         standby   = 1'b0;
  // register bus
  logic         awvalid = 1'b0, awready, wvalid = 1'b0, wready;
  logic         bvalid, bready = 1'b0, arvalid = 1'b0, arready;
  logic         rvalid, rready = 1'b0;
  logic [3:0]   awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0]  wdata = 32'h0, rdata, rv;
  logic [1:0]   bresp, rresp, rsp, rd_fld = 2'h0, wr_fld = 2'h0;
  // access side and far device
  access_req_t  req = '0;
  access_stat_t stat;
  logic         go = 1'b0, wait_n, en;
  logic [7:0]   hold = 8'h00;
  logic [15:0]  cs = 16'hF520; // per-space counts under test
  int           error_cnt = 0, compares = 0, lat;

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  external_bus_wait_control i_dut (
    .clk_sys_i(clk_sys_i), .reset_i(reset_i), .manual_reset_i(man_rst),
    .software_standby_i(standby), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .dram_read_wait_field_i(rd_fld),
    .dram_write_wait_field_i(wr_fld), .access_req_i(req), .access_stat_o(stat),
    .ext_wait_n_i(wait_n));

  ext_wait_device i_dev (.clk_sys_i(clk_sys_i), .go_i(go), .hold_i(hold),
    .wait_n_o(wait_n));

  // compare and count
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  // one write, address and data offered together
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ta, tw;
    @(posedge clk_sys_i);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1;
    wdata <= d; wstrb <= 4'hF; bready <= 1'b1;
    for (int i = 0; i < 100; i++)
    begin
      @(negedge clk_sys_i);
      if (!awvalid && !wvalid) break;
      ta = awready; tw = wready;
      @(posedge clk_sys_i);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    for (int i = 0; i < 100 && bvalid !== 1'b1; i++) @(negedge clk_sys_i);
    rsp = bresp;
    @(posedge clk_sys_i);
    bready <= 1'b0;
  endtask : wr

  // one read, data and response kept in rv and rsp
  task rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (int i = 0; i < 100 && arready !== 1'b1; i++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    arvalid <= 1'b0;
    for (int i = 0; i < 100 && rvalid !== 1'b1; i++) @(negedge clk_sys_i);
    rv = rdata; rsp = rresp;
    @(posedge clk_sys_i);
    rready <= 1'b0;
  endtask : rd

  // one access; lat counts edges from take to done
  task acc(input space_t sp, input logic dm, input logic w, input logic [7:0] h);
    repeat (4) @(posedge clk_sys_i);
    req <= '{1'b1, sp, dm, w}; go <= 1'b1; hold <= h;
    @(posedge clk_sys_i);
    req.start <= 1'b0; go <= 1'b0;
    lat = 0; en = 1'b0;
    for (int i = 0; i < 300; i++)
    begin
      #1;
      en = en | stat.ext_wait_en;
      if (stat.done === 1'b1) break;
      @(posedge clk_sys_i);
      lat++;
    end
  endtask : acc

  // verdict and end of run
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // watchdog for a hung handshake
  initial
  begin
    #(40 * 20000);
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    rd(CS_WAIT_OFFSET); check(rv, 32'h0000FFFF);
    rd(DMA_WAIT_OFFSET); check(rv, 32'h0000000F);
    wr(CS_WAIT_OFFSET, 32'hFFFFF520);
    check(32'(rsp), 32'(RESP_OKAY));
    rd(CS_WAIT_OFFSET);
    check(rv, 32'h0000F520);
    // reserved bits are written as zero, as software must
    wr(DMA_WAIT_OFFSET, 32'h00000025);
    rd(DMA_WAIT_OFFSET);
    check(rv, 32'h00000025);
    rd(4'hC); check(32'(rsp), 32'(RESP_SLVERR));
    // manual reset and standby keep both registers
    @(posedge clk_sys_i);
    man_rst <= 1'b1; standby <= 1'b1;
    @(posedge clk_sys_i);
    man_rst <= 1'b0; standby <= 1'b0;
    rd(CS_WAIT_OFFSET); check(rv, 32'h0000F520);
    rd(DMA_WAIT_OFFSET); check(rv, 32'h00000025);
    $display("test registers done");
    // each space takes its own count
    for (int s = 0; s < 4; s++)
    begin
      acc(space_t'(s), 1'b0, 1'b0, 8'h00);
      check(32'(lat), 32'(cs[4*s +: 4]));
      check(32'(en), 32'(cs[4*s +: 4] != 4'h0));
    end
    acc(SPACE_CS0, 1'b0, 1'b0, 8'h28); check(32'(lat), 32'h0);
    check(32'(en), 32'h0);
    acc(SPACE_CS2, 1'b0, 1'b0, 8'h0A); check(32'(lat >= 11 && lat <= 15), 32'h1);
    $display("test spaces done");
    // DRAM codes under single address and normal transfers
    rd_fld <= 2'h3; wr_fld <= 2'h3;
    for (int c = 0; c < 4; c++)
    begin
      wr(DMA_WAIT_OFFSET, 32'(c * 16 + 3));
      acc(SPACE_DRAM, 1'b1, 1'b0, 8'h00); check(32'(lat), 32'(c));
      check(32'(en), 32'(c / 2));
    end
    rd_fld <= 2'h1; wr_fld <= 2'h2;
    acc(SPACE_DRAM, 1'b0, 1'b0, 8'h00); check(32'(lat), 32'h1);
    acc(SPACE_DRAM, 1'b0, 1'b1, 8'h00); check(32'(lat), 32'h2);
    // chip-select count under single address transfers
    wr(DMA_WAIT_OFFSET, 32'h00000003);
    acc(SPACE_CS3, 1'b1, 1'b0, 8'h00); check(32'(lat), 32'h3);
    wr(DMA_WAIT_OFFSET, 32'h00000000);
    acc(SPACE_CS3, 1'b1, 1'b1, 8'h28); check(32'(lat), 32'h0);
    check(32'(en), 32'h0);
    $display("test dma done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
